// *** logic/mmnd_defs.vh ***
// constants for the move, multiply and not decode block
//
// Notes on behaviour
// RULE1 - alternate pair read passes a 4-bit opcode, 0 to 15, to the coprocessor
// RULE2 - trailing-2 pair read is C bit 1; plain form is C bit 0
// RULE3 - 4-bit selector field addresses coprocessors 0 to 15
// RULE4 - pair read offered when condition passes; rejection raises usage fault
// RULE5 - accepted pair read: word one to first dest, word two to second
// RULE6 - special read is privileged unless source is app status or control
// RULE7 - special write is privileged unless destination is app status register
// RULE8 - multiply writes low 32 product bits; sign does not matter
// RULE9 - short multiply: second operand is destination; flags only outside IT
// RULE10 - not-immediate writes complement of expanded 32-bit immediate
// RULE11 - not flags: N bit 31, Z zero, C from expander or shifter, V kept
// RULE12 - not-immediate unpredictable when destination is 13 or 15
// RULE13 - not-register shifts source by decoded shift then writes complement
// RULE14 - short not-register uses shift left by zero; flags only outside IT
// RULE15 - explicit shift only in wide not-register form; no shift in short form
// RULE16 - wide not-register unpredictable when destination or source is 13 or 15
// RULE17 - wide multiply never sets flags; unpredictable if any register 13 or 15
// RULE18 - short multiply flags: N bit 31, Z zero, C and V kept
`ifndef MMND_DEFS_VH
`define MMND_DEFS_VH

// register numbers that some encodings forbid
`define MMND_REG_SP 4'hd
`define MMND_REG_PC 4'hf

// short encodings, bits 15:6
`define MMND_MUL16_OP 10'h10d
`define MMND_MVN16_OP 10'h10f

// pair read: hw1 15:13 and 11:4, C bit at hw1 12
`define MMND_MRRC_TOP 3'h7
`define MMND_MRRC_OP 8'hc5
`define MMND_MRRC_CBIT 12

// special register moves: hw1 15:5, hw2 15:14
`define MMND_MRS_OP 11'h79f
`define MMND_MSR_OP 11'h79c
`define MMND_SREG_HW2 2'h2
`define MMND_SEL_APP_STATUS_REG 8'h00
`define MMND_SEL_CONTROL 8'h14

// wide multiply: hw1 15:4, hw2 15:12 and 7:4
`define MMND_MUL32_OP 12'hfb0
`define MMND_MUL32_HI 4'hf
`define MMND_MUL32_LO 4'h0

// wide not forms
`define MMND_MVNI_TOP 5'h1e
`define MMND_MVNI_MID 5'h03
`define MMND_MVNR_OP 11'h753

// shift types
`define MMND_SH_LSL 2'h0
`define MMND_SH_LSR 2'h1
`define MMND_SH_ASR 2'h2
`define MMND_SH_ROR 2'h3
`define MMND_SH_FULL 6'h20

// pair read sequencer states
`define MMND_ST_IDLE 2'h0
`define MMND_ST_WAIT 2'h1
`define MMND_ST_WR2 2'h2

`endif

// *** logic/mmnd_imm_expand.v ***
// modified immediate expander with carry out
`timescale 1ns/1ns
module mmnd_imm_expand
(
    input wire [11:0] imm12_i,
    input wire carry_i,
    output reg [31:0] value_o,
    output reg carry_o
);

// =============================================
// expansion
// =============================================
reg [31:0] unrot;
reg [4:0] rot;
// replicated byte patterns or rotated 8-bit value
always @*
begin
    unrot = {24'h000000, 1'b1, imm12_i[6:0]};
    rot = imm12_i[11:7];
    value_o = 32'h00000000;
    carry_o = carry_i;
    if (imm12_i[11:10] == 2'h0)
    begin
        case (imm12_i[9:8])
            2'h0: value_o = {24'h000000, imm12_i[7:0]};
            2'h1: value_o = {8'h00, imm12_i[7:0], 8'h00, imm12_i[7:0]};
            2'h2: value_o = {imm12_i[7:0], 8'h00, imm12_i[7:0], 8'h00};
            default: value_o = {4{imm12_i[7:0]}};
        endcase
    end
    else
    begin
        value_o = (unrot >> rot) | (unrot << (6'h20 - {1'b0, rot}));
        carry_o = value_o[31]; // rotated forms carry out bit 31
    end
end

endmodule // mmnd_imm_expand

// *** logic/mmnd_shifter.v ***
// immediate shift decode and barrel shifter with carry out
`timescale 1ns/1ns
`include "mmnd_defs.vh"
module mmnd_shifter
(
    input wire [31:0] value_i,
    input wire [1:0] type_i,
    input wire [4:0] imm5_i,
    input wire carry_i,
    output reg [31:0] result_o,
    output reg carry_o
);

// =============================================
// shift
// =============================================
reg [5:0] amt;
reg [32:0] tmp;
// zero amount means 32 for right shifts and rrx for rotate
always @*
begin
    amt = (imm5_i == 5'h00) ? `MMND_SH_FULL : {1'b0, imm5_i};
    tmp = 33'h000000000;
    result_o = value_i;
    carry_o = carry_i;
    case (type_i)
        `MMND_SH_LSL:
        begin
            tmp = {1'b0, value_i} << imm5_i;
            result_o = tmp[31:0];
            if (imm5_i != 5'h00)
                carry_o = tmp[32];
        end
        `MMND_SH_LSR:
        begin
            tmp = {value_i, 1'b0} >> amt;
            result_o = tmp[32:1];
            carry_o = tmp[0];
        end
        `MMND_SH_ASR:
        begin
            tmp = $signed({value_i, 1'b0}) >>> amt;
            result_o = tmp[32:1];
            carry_o = tmp[0];
        end
        default:
        begin
            if (imm5_i == 5'h00)
            begin
                result_o = {carry_i, value_i[31:1]}; // rrx
                carry_o = value_i[0];
            end
            else
            begin
                result_o = (value_i >> imm5_i) |
                    (value_i << (6'h20 - {1'b0, imm5_i}));
                carry_o = result_o[31];
            end
        end
    endcase
end

endmodule // mmnd_shifter

// *** logic/mmnd_decode.v ***
// decode and execute for pair read, special moves, multiply and not
`timescale 1ns/1ns
`include "mmnd_defs.vh"
module mmnd_decode
(
    input wire clock_i,
    input wire rst_i,
    input wire instr_valid_i,
    input wire wide_i,
    input wire [31:0] instr_i,
    input wire cond_pass_i,
    input wire in_it_block_i,
    input wire privileged_i,
    input wire [31:0] rdata_a_i,
    input wire [31:0] rdata_b_i,
    input wire flag_n_i,
    input wire flag_z_i,
    input wire flag_c_i,
    input wire flag_v_i,
    input wire [31:0] sreg_rdata_i,
    input wire cp_accept_i,
    input wire cp_reject_i,
    input wire [31:0] cp_word1_i,
    input wire [31:0] cp_word2_i,
    output wire busy_o,
    output reg [3:0] rd_addr_a_o,
    output reg [3:0] rd_addr_b_o,
    output wire [7:0] sreg_sel_o,
    output reg wr_en_o,
    output reg [3:0] wr_addr_o,
    output reg [31:0] wr_data_o,
    output reg flag_we_o,
    output reg flag_n_o,
    output reg flag_z_o,
    output reg flag_c_o,
    output reg flag_v_o,
    output reg sreg_wr_o,
    output reg [7:0] sreg_wsel_o,
    output reg [1:0] sreg_mask_o,
    output reg [31:0] sreg_wdata_o,
    output reg cp_req_o,
    output reg cp_alt_o,
    output reg [3:0] cp_num_o,
    output reg [3:0] cp_opcode_o,
    output reg [3:0] cp_crm_o,
    output reg usage_fault_o,
    output reg priv_fault_o,
    output reg unpredictable_o,
    output reg undefined_o
);

// =============================================
// helpers
// =============================================
// register number 13 or 15
function is_sp_pc;
    input [3:0] r;
    begin
        is_sp_pc = (r == `MMND_REG_SP) || (r == `MMND_REG_PC);
    end
endfunction

wire [15:0] hw1 = instr_i[31:16];
wire [15:0] hw2 = instr_i[15:0];
reg [1:0] state;
reg [3:0] cp_dest2;
reg [31:0] cp_hold2;
wire idle = (state == `MMND_ST_IDLE);

assign busy_o = !idle;
assign sreg_sel_o = hw2[7:0];

// =============================================
// encoding match
// =============================================
// short forms sit in the low halfword
wire dec_mul16 = !wide_i && (hw2[15:6] == `MMND_MUL16_OP);
wire dec_mvn16 = !wide_i && (hw2[15:6] == `MMND_MVN16_OP);
// both C forms of the pair read decode here; C goes out as cp_alt
wire dec_mrrc = wide_i && (hw1[15:13] == `MMND_MRRC_TOP) &&
    (hw1[11:4] == `MMND_MRRC_OP); // [RULE2]
wire dec_mrs = wide_i && (hw1[15:5] == `MMND_MRS_OP) &&
    (hw2[15:14] == `MMND_SREG_HW2) && !hw2[12];
wire dec_msr = wide_i && (hw1[15:5] == `MMND_MSR_OP) &&
    (hw2[15:14] == `MMND_SREG_HW2) && !hw2[12];
wire dec_mul32 = wide_i && (hw1[15:4] == `MMND_MUL32_OP) &&
    (hw2[15:12] == `MMND_MUL32_HI) && (hw2[7:4] == `MMND_MUL32_LO);
wire dec_mvni = wide_i && (hw1[15:11] == `MMND_MVNI_TOP) &&
    (hw1[9:5] == `MMND_MVNI_MID) && (hw1[3:0] == `MMND_REG_PC) &&
    !hw2[15];
// explicit shift fields exist only in this wide form
wire dec_mvnr = wide_i && (hw1[15:5] == `MMND_MVNR_OP) &&
    (hw1[3:0] == `MMND_REG_PC) && !hw2[15]; // [RULE15]

// =============================================
// operand reads
// =============================================
// register file read addresses, answered in the same cycle
always @*
begin
    rd_addr_a_o = 4'h0;
    rd_addr_b_o = 4'h0;
    if (dec_mul16)
    begin
        rd_addr_a_o = {1'b0, hw2[5:3]}; // [RULE9]
        rd_addr_b_o = {1'b0, hw2[2:0]}; // [RULE9]
    end
    else if (dec_mvn16)
        rd_addr_a_o = {1'b0, hw2[5:3]};
    else if (dec_mul32)
    begin
        rd_addr_a_o = hw1[3:0];
        rd_addr_b_o = hw2[3:0];
    end
    else if (dec_mvnr)
        rd_addr_a_o = hw2[3:0];
    else if (dec_msr)
        rd_addr_a_o = hw1[3:0];
end

// =============================================
// datapath
// =============================================
wire [31:0] imm_value;
wire imm_carry;
wire [31:0] sh_value;
wire sh_carry;
wire [63:0] product = rdata_a_i * rdata_b_i;
wire [31:0] prod_lo = product[31:0]; // [RULE8]
// short form uses lsl #0, which leaves the source and carry untouched
wire [1:0] sh_type = dec_mvn16 ? `MMND_SH_LSL : hw2[5:4]; // [RULE14]
wire [4:0] sh_imm = dec_mvn16 ? 5'h00 : {hw2[14:12], hw2[7:6]}; // [RULE14]

mmnd_imm_expand u_imm
(
    .imm12_i({hw1[10], hw2[14:12], hw2[7:0]}),
    .carry_i(flag_c_i),
    .value_o(imm_value),
    .carry_o(imm_carry)
);

mmnd_shifter u_shift
(
    .value_i(rdata_a_i),
    .type_i(sh_type),
    .imm5_i(sh_imm),
    .carry_i(flag_c_i),
    .result_o(sh_value),
    .carry_o(sh_carry)
);

// =============================================
// single cycle execute decision
// =============================================
reg ex_we;
reg [3:0] ex_dest;
reg [31:0] ex_data;
reg ex_fl;
reg ex_c;
reg ex_unpred;
reg ex_priv;
reg ex_undef;
wire sel_app_status_reg = (hw2[7:0] == `MMND_SEL_APP_STATUS_REG);
wire sel_ctrl = (hw2[7:0] == `MMND_SEL_CONTROL);
always @*
begin
    ex_we = 1'b0;
    ex_dest = hw2[11:8];
    ex_data = 32'h00000000;
    ex_fl = 1'b0;
    ex_c = flag_c_i;
    ex_unpred = 1'b0;
    ex_priv = 1'b0;
    ex_undef = 1'b0;
    if (dec_mul16)
    begin
        ex_we = 1'b1;
        ex_dest = {1'b0, hw2[2:0]}; // [RULE9]
        ex_data = prod_lo;
        ex_fl = !in_it_block_i; // [RULE9] [RULE18]
    end
    else if (dec_mul32)
    begin
        ex_we = 1'b1;
        ex_data = prod_lo; // [RULE8]
        ex_unpred = is_sp_pc(hw2[11:8]) || is_sp_pc(hw1[3:0]) ||
            is_sp_pc(hw2[3:0]); // [RULE17]
    end
    else if (dec_mvni)
    begin
        ex_we = 1'b1;
        ex_data = ~imm_value; // [RULE10]
        ex_fl = hw1[4];
        ex_c = imm_carry; // [RULE11]
        ex_unpred = is_sp_pc(hw2[11:8]); // [RULE12]
    end
    else if (dec_mvnr || dec_mvn16)
    begin
        ex_we = 1'b1;
        ex_data = ~sh_value; // [RULE13]
        ex_c = sh_carry; // [RULE11]
        if (dec_mvn16)
        begin
            ex_dest = {1'b0, hw2[2:0]};
            ex_fl = !in_it_block_i; // [RULE14]
        end
        else
        begin
            ex_fl = hw1[4];
            ex_unpred = is_sp_pc(hw2[11:8]) ||
                is_sp_pc(hw2[3:0]); // [RULE16]
        end
    end
    else if (dec_mrs)
    begin
        ex_we = 1'b1;
        ex_data = sreg_rdata_i;
        ex_priv = !privileged_i && !sel_app_status_reg && !sel_ctrl; // [RULE6]
    end
    else if (dec_msr)
        ex_priv = !privileged_i && !sel_app_status_reg; // [RULE7]
    else if (dec_mrrc)
        ex_unpred = (hw2[15:12] == `MMND_REG_PC) ||
            (hw1[3:0] == `MMND_REG_PC) || (hw2[15:12] == hw1[3:0]) ||
            (hw2[15:12] == `MMND_REG_SP) || (hw1[3:0] == `MMND_REG_SP);
    else
        ex_undef = 1'b1;
end

wire take = instr_valid_i && idle && cond_pass_i;
wire go = take && !ex_unpred && !ex_priv && !ex_undef;

// =============================================
// outputs and pair read sequencer
// =============================================
// pulses last one cycle; pair read writes its two words on two edges
always @(posedge clock_i or posedge rst_i)
begin
    if (rst_i)
    begin
        state <= `MMND_ST_IDLE;
        cp_dest2 <= 4'h0;
        cp_hold2 <= 32'h00000000;
        wr_en_o <= 1'b0;
        wr_addr_o <= 4'h0;
        wr_data_o <= 32'h00000000;
        flag_we_o <= 1'b0;
        flag_n_o <= 1'b0;
        flag_z_o <= 1'b0;
        flag_c_o <= 1'b0;
        flag_v_o <= 1'b0;
        sreg_wr_o <= 1'b0;
        sreg_wsel_o <= 8'h00;
        sreg_mask_o <= 2'h0;
        sreg_wdata_o <= 32'h00000000;
        cp_req_o <= 1'b0;
        cp_alt_o <= 1'b0;
        cp_num_o <= 4'h0;
        cp_opcode_o <= 4'h0;
        cp_crm_o <= 4'h0;
        usage_fault_o <= 1'b0;
        priv_fault_o <= 1'b0;
        unpredictable_o <= 1'b0;
        undefined_o <= 1'b0;
    end
    else
    begin
        wr_en_o <= 1'b0;
        flag_we_o <= 1'b0;
        sreg_wr_o <= 1'b0;
        usage_fault_o <= 1'b0;
        priv_fault_o <= 1'b0;
        unpredictable_o <= 1'b0;
        undefined_o <= 1'b0;
        case (state)
            `MMND_ST_IDLE:
            begin
                unpredictable_o <= take && ex_unpred;
                priv_fault_o <= take && ex_priv;
                undefined_o <= take && ex_undef;
                if (go && dec_mrrc)
                begin
                    cp_req_o <= 1'b1; // [RULE4]
                    cp_alt_o <= hw1[`MMND_MRRC_CBIT]; // [RULE2]
                    cp_num_o <= hw2[11:8]; // [RULE3]
                    cp_opcode_o <= hw2[7:4]; // [RULE1]
                    cp_crm_o <= hw2[3:0];
                    wr_addr_o <= hw2[15:12];
                    cp_dest2 <= hw1[3:0];
                    state <= `MMND_ST_WAIT;
                end
                else if (go && dec_msr)
                begin
                    sreg_wr_o <= 1'b1;
                    sreg_wsel_o <= hw2[7:0];
                    sreg_mask_o <= hw2[11:10];
                    sreg_wdata_o <= rdata_a_i;
                end
                else if (go)
                begin
                    wr_en_o <= ex_we;
                    wr_addr_o <= ex_dest;
                    wr_data_o <= ex_data;
                    flag_we_o <= ex_fl;
                    flag_n_o <= ex_data[31]; // [RULE11] [RULE18]
                    flag_z_o <= (ex_data == 32'h00000000); // [RULE11]
                    flag_c_o <= ex_c; // [RULE11] [RULE18]
                    flag_v_o <= flag_v_i; // [RULE11] [RULE18]
                end
            end
            `MMND_ST_WAIT:
            begin
                // rejection wins if the coprocessor raises both
                if (cp_reject_i)
                begin
                    cp_req_o <= 1'b0;
                    usage_fault_o <= 1'b1; // [RULE4]
                    state <= `MMND_ST_IDLE;
                end
                else if (cp_accept_i)
                begin
                    cp_req_o <= 1'b0;
                    wr_en_o <= 1'b1; // [RULE5]
                    wr_data_o <= cp_word1_i; // [RULE5]
                    cp_hold2 <= cp_word2_i;
                    state <= `MMND_ST_WR2;
                end
            end
            `MMND_ST_WR2:
            begin
                wr_en_o <= 1'b1;
                wr_addr_o <= cp_dest2; // [RULE5]
                wr_data_o <= cp_hold2; // [RULE5]
                state <= `MMND_ST_IDLE;
            end
            default:
                state <= `MMND_ST_IDLE;
        endcase
    end
end

endmodule // mmnd_decode

// *** sim/mmnd_copro_model.sv ***
// coprocessor stand-in that answers pair reads
`timescale 1ns/1ns
module mmnd_copro_model
(
    input wire clock_i,
    input wire rst_i,
    input wire req_i,
    input wire refuse_i,
    input wire slow_i,
    input wire [3:0] num_i,
    input wire [3:0] opcode_i,
    input wire [3:0] crm_i,
    output logic accept_o,
    output logic reject_o,
    output wire [31:0] word1_o,
    output wire [31:0] word2_o
);
    logic [1:0] wait_cnt;
    wire [31:0] w1 = {20'h5a5a5, num_i, opcode_i, crm_i};
    wire [31:0] w2 = {crm_i, opcode_i, num_i, 20'h3c3c3};
    // answer after zero or three idle cycles, hold the answer one cycle
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            accept_o <= 1'b0;
            reject_o <= 1'b0;
            wait_cnt <= 2'h0;
        end
        else if (accept_o || reject_o)
        begin
            accept_o <= 1'b0;
            reject_o <= 1'b0;
            wait_cnt <= 2'h0;
        end
        else if (req_i)
        begin
            if (wait_cnt == {slow_i, slow_i})
            begin
                accept_o <= !refuse_i;
                reject_o <= refuse_i;
            end
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
    // words are real only while accepting, inverted otherwise
    assign word1_o = accept_o ? w1 : ~w1;
    assign word2_o = accept_o ? w2 : ~w2;
endmodule // mmnd_copro_model

// *** sim/mmnd_decode_chk.sv ***
// port-level assertions for the decode block
`timescale 1ns/1ns
module mmnd_decode_chk
(
    input wire clock_i,
    input wire rst_i,
    input wire instr_valid_i,
    input wire wide_i,
    input wire [31:0] instr_i,
    input wire cond_pass_i,
    input wire in_it_block_i,
    input wire privileged_i,
    input wire [31:0] rdata_a_i,
    input wire [31:0] rdata_b_i,
    input wire flag_c_i,
    input wire cp_accept_i,
    input wire cp_reject_i,
    input wire [31:0] cp_word1_i,
    input wire [31:0] cp_word2_i,
    input wire busy_o,
    input wire wr_en_o,
    input wire [3:0] wr_addr_o,
    input wire [31:0] wr_data_o,
    input wire flag_we_o,
    input wire flag_n_o,
    input wire flag_z_o,
    input wire flag_c_o,
    input wire sreg_wr_o,
    input wire cp_req_o,
    input wire cp_alt_o,
    input wire [3:0] cp_num_o,
    input wire [3:0] cp_opcode_o,
    input wire usage_fault_o,
    input wire priv_fault_o,
    input wire unpredictable_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    // =========================================
    // instruction classes at the taking edge
    wire take = instr_valid_i && !busy_o && cond_pass_i && wide_i;
    wire [15:0] h1 = instr_i[31:16];
    wire [15:0] h2 = instr_i[15:0];
    wire sel_ok = h2[7:0] == 8'h00 || h2[7:0] == 8'h14;
    wire is_srd = take && h1 == 16'hf3ef && h2[15:12] == 4'h8;
    wire is_swr = take && h1[15:4] == 12'hf38 && h2[15:12] == 4'h8;
    wire is_p16 = instr_valid_i && !busy_o && cond_pass_i && !wide_i
        && instr_i[15:6] == 10'h10d;
    wire is_p32 = take && h1[15:4] == 12'hfb0 && h2[15:12] == 4'hf;
    wire is_nimm = take && h1[15:11] == 5'h1e && h1[9:5] == 5'h03
        && h1[3:0] == 4'hf && !h2[15];
    wire is_nreg = take && h1[15:5] == 11'h753 && h1[3:0] == 4'hf && !h2[15];
    wire bad_d = h2[11:8] == 4'hd || h2[11:8] == 4'hf;
    wire bad_m = h2[3:0] == 4'hd || h2[3:0] == 4'hf;
    // =========================================
    // pair read steps
    sequence pair_go;
        cp_req_o && cp_accept_i && !cp_reject_i;
    endsequence
    sequence pair_wr;
        wr_en_o && wr_data_o == $past(cp_word1_i)
        ##1 wr_en_o && wr_data_o == $past(cp_word2_i, 2);
    endsequence
    chk_pair_words: assert property (pair_go |=> pair_wr)
        else $error("pair words not written in order");
    chk_reject_fault: assert property (cp_req_o && cp_reject_i
        |=> usage_fault_o && !wr_en_o && !cp_req_o)
        else $error("rejected pair read without usage fault");
    chk_req_fields: assert property ($rose(cp_req_o)
        |-> cp_alt_o == $past(instr_i[28]) && cp_num_o == $past(instr_i[11:8])
        && cp_opcode_o == $past(instr_i[7:4]))
        else $error("request fields differ from instruction");
    chk_read_priv: assert property (is_srd && !privileged_i && !sel_ok
        |=> priv_fault_o && !wr_en_o)
        else $error("unprivileged special read not refused");
    chk_write_priv: assert property (is_swr && !privileged_i
        |=> sreg_wr_o == ($past(instr_i[7:0]) == 8'h00)
        && priv_fault_o != sreg_wr_o)
        else $error("special write privilege wrong");
    chk_prod_short: assert property (is_p16
        |=> wr_en_o && wr_addr_o == {1'b0, $past(instr_i[2:0])}
        && wr_data_o == 32'($past(rdata_a_i) * $past(rdata_b_i))
        && flag_we_o == !$past(in_it_block_i))
        else $error("short product result or flag enable wrong");
    chk_prod_flags: assert property (is_p16 && !in_it_block_i
        |=> flag_n_o == wr_data_o[31] && flag_z_o == (wr_data_o == 32'h0)
        && flag_c_o == $past(flag_c_i))
        else $error("short product flags wrong");
    chk_prod_wide: assert property (is_p32 |=> !flag_we_o)
        else $error("wide product updated flags");
    chk_nimm_bad: assert property (is_nimm && bad_d
        |=> unpredictable_o && !wr_en_o && !flag_we_o)
        else $error("bad not-immediate destination accepted");
    chk_nreg_bad: assert property (is_nreg && (bad_d || bad_m)
        |=> unpredictable_o && !wr_en_o)
        else $error("bad not-register operand accepted");
endmodule // mmnd_decode_chk

// checker ports share the names of the decode block's ports
bind mmnd_decode mmnd_decode_chk u_chk (.*);

// *** sim/mmnd_decode_tb.sv ***
// self-checking bench for the decode block
`timescale 1ns/1ns
module mmnd_decode_tb;
    logic clock_i = 0, rst_i = 1, instr_valid_i = 0, wide_i = 0;
    logic cond_pass_i = 1, in_it_block_i = 0, privileged_i = 1;
    logic flag_n_i = 0, flag_z_i = 0, flag_c_i = 0, flag_v_i = 1;
    logic refuse = 0, slow = 0;
    logic [31:0] instr_i = 0, p, v, s;
    logic c;
    wire cp_accept_i, cp_reject_i, busy_o, wr_en_o, flag_we_o, flag_n_o;
    wire flag_z_o, flag_c_o, flag_v_o, sreg_wr_o, cp_req_o, cp_alt_o;
    wire usage_fault_o, priv_fault_o, unpredictable_o, undefined_o;
    wire [3:0] rd_addr_a_o, rd_addr_b_o, wr_addr_o;
    wire [3:0] cp_num_o, cp_opcode_o, cp_crm_o;
    wire [7:0] sreg_sel_o, sreg_wsel_o;
    wire [1:0] sreg_mask_o;
    wire [31:0] rdata_a_i, rdata_b_i, sreg_rdata_i, cp_word1_i, cp_word2_i;
    wire [31:0] wr_data_o, sreg_wdata_o;
    int failures = 0, compares = 0;
    // =========================================
    // register file and special register stand-ins
    function automatic [31:0] rv(input logic [3:0] a);
        rv = 32'h87654321 ^ {8{a}};
    endfunction
    assign rdata_a_i = rv(rd_addr_a_o);
    assign rdata_b_i = rv(rd_addr_b_o);
    assign sreg_rdata_i = {24'h0, sreg_sel_o} ^ 32'ha5000000;
    always #50 clock_i = ~clock_i;
    // every bench signal that meets the decode block carries the name of its port
    mmnd_decode u_mmnd_decode (.*);
    mmnd_copro_model u_mmnd_copro_model
    (
        .clock_i(clock_i), .rst_i(rst_i), .req_i(cp_req_o),
        .refuse_i(refuse), .slow_i(slow), .num_i(cp_num_o),
        .opcode_i(cp_opcode_o), .crm_i(cp_crm_o), .accept_o(cp_accept_i),
        .reject_o(cp_reject_i), .word1_o(cp_word1_i), .word2_o(cp_word2_i)
    );
    // =========================================
    // encoders, access tasks and comparison
    function automatic [31:0] not_imm(input logic [11:0] m, input logic [3:0] d);
        not_imm = {5'h1e, m[11], 5'h03, 1'b1, 4'hf, 1'b0, m[10:8], d, m[7:0]};
    endfunction
    function automatic [31:0] not_reg(input logic [1:0] t, input logic [3:0] d,
        input logic [3:0] m);
        not_reg = {11'h753, 1'b1, 4'hf, 1'b0, 3'h1, d, 2'h0, t, m};
    endfunction
    task wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // present one instruction; return just after the edge that takes it
    task run(input logic w, input logic [31:0] ins);
        @(posedge clock_i);
        instr_valid_i <= 1'b1;
        wide_i <= w;
        instr_i <= ins;
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask
    task ex(input logic w, input logic [31:0] ins, input logic [3:0] d,
        input logic [31:0] val, input logic [4:0] f);
        run(w, ins);
        chk({wr_en_o, wr_addr_o, wr_data_o}, {1'b1, d, val}, "write");
        chk(flag_we_o, f[4], "flag enable");
        if (f[4])
            chk({flag_n_o, flag_z_o, flag_c_o, flag_v_o}, f[3:0], "flags");
    endtask
    task bad(input logic w, input logic [31:0] ins, input logic [4:0] f);
        run(w, ins);
        chk({usage_fault_o, priv_fault_o, unpredictable_o, undefined_o,
            wr_en_o}, f, "faults");
    endtask
    task wait_ans;
        int i;
        for (i = 0; i < 20; i++)
        begin
            if (wr_en_o === 1'b1 || usage_fault_o === 1'b1)
                break;
            @(posedge clock_i);
            #1;
        end
        if (i == 20)
        begin
            failures++;
            wrap_up;
        end
    endtask
    task pair(input logic a);
        logic [3:0] f;
        f = {4{a}};
        slow <= a;
        run(1'b1, {3'h7, a, 8'hc5, 4'h6, 4'h5, f, f, 4'h9});
        chk({cp_req_o, busy_o, cp_alt_o, cp_num_o, cp_opcode_o, cp_crm_o},
            {2'b11, a, f, f, 4'h9}, "request");
        wait_ans;
        chk({wr_en_o, wr_addr_o, wr_data_o}, {1'b1, 4'h5, 20'h5a5a5, f, f,
            4'h9}, "word one");
        @(posedge clock_i);
        #1;
        chk({wr_en_o, wr_addr_o, wr_data_o}, {1'b1, 4'h6, 4'h9, f, f,
            20'h3c3c3}, "word two");
    endtask
    // =========================================
    // main sequence
    initial
    begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        ex(1, not_imm(12'h0ab, 4'h2), 4'h2, 32'hffffff54, 5'h19);
        ex(1, not_imm(12'h400, 4'h3), 4'h3, 32'h7fffffff, 5'h13);
        ex(1, not_imm(12'h3ff, 4'h4), 4'h4, 32'h0, 5'h15);
        bad(1, not_imm(12'h0ab, 4'hd), 5'h04);
        bad(1, not_imm(12'h0ab, 4'hf), 5'h04);
        p = rv(4'h2) * rv(4'h3);
        ex(0, {10'h10d, 6'h13}, 4'h3, p, {1'b1, p[31], p == 0, 2'h1});
        in_it_block_i <= 1'b1;
        ex(0, {10'h10d, 6'h13}, 4'h3, p, 5'h0);
        ex(0, {10'h10f, 6'h0a}, 4'h2, ~rv(4'h1), 5'h0);
        in_it_block_i <= 1'b0;
        v = ~rv(4'h1);
        ex(0, {10'h10f, 6'h0a}, 4'h2, v, {1'b1, v[31], 3'h1});
        p = rv(4'h5) * rv(4'h6);
        ex(1, {12'hfb0, 4'h5, 4'hf, 4'h4, 4'h0, 4'h6}, 4'h4, p, 5'h0);
        bad(1, {12'hfb0, 4'h5, 4'hf, 4'h4, 4'h0, 4'hd}, 5'h04);
        v = rv(4'h7);
        for (int t = 0; t < 4; t++)
        begin
            s = t == 0 ? v << 4 : t == 1 ? v >> 4 : t == 2 ?
                {{4{v[31]}}, v[31:4]} : {v[3:0], v[31:4]};
            c = t == 0 ? v[28] : v[3];
            ex(1, not_reg(t[1:0], 4'h8, 4'h7), 4'h8, ~s,
                {1'b1, ~s[31], ~s == 0, c, 1'b1});
        end
        bad(1, not_reg(2'h0, 4'h8, 4'hd), 5'h04);
        bad(1, not_reg(2'h0, 4'hf, 4'h7), 5'h04);
        bad(1, not_reg(2'h0, 4'h8, 4'h7) | 32'h8000, 5'h02);
        privileged_i <= 1'b0;
        ex(1, {16'hf3ef, 8'h81, 8'h00}, 4'h1, 32'ha5000000, 5'h0);
        ex(1, {16'hf3ef, 8'h81, 8'h14}, 4'h1, 32'ha5000014, 5'h0);
        bad(1, {16'hf3ef, 8'h81, 8'h08}, 5'h08);
        run(1, {12'hf38, 4'h3, 8'h88, 8'h00});
        chk({sreg_wr_o, sreg_wsel_o, sreg_mask_o, sreg_wdata_o},
            {1'b1, 8'h00, 2'h2, rv(4'h3)}, "special write");
        bad(1, {12'hf38, 4'h3, 8'h88, 8'h14}, 5'h08);
        privileged_i <= 1'b1;
        run(1, {12'hf38, 4'h3, 8'h88, 8'h14});
        chk({sreg_wr_o, sreg_wsel_o}, {1'b1, 8'h14}, "special write");
        pair(1'b0);
        pair(1'b1);
        refuse <= 1'b1;
        run(1, {3'h7, 1'b1, 8'hc5, 4'h2, 4'h1, 4'h5, 4'ha, 4'h9});
        wait_ans;
        chk({usage_fault_o, wr_en_o, busy_o}, 3'h4, "reject");
        refuse <= 1'b0;
        cond_pass_i <= 1'b0;
        run(1, {3'h7, 1'b1, 8'hc5, 4'h2, 4'h1, 4'h5, 4'ha, 4'h9});
        chk({cp_req_o, busy_o, wr_en_o}, 3'h0, "skipped");
        wrap_up;
    end
endmodule // mmnd_decode_tb
